//--- rtl/epsl_top.sv
`timescale 1ns/1ps
// =========================================================
// response byte buffer
module epsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem_r[rp_r];
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wp_r] <= in_data_i;
  end
endmodule

// What this block does
// [R1] request strobe falling edge starts position read
// [R2] master keeps shift clock at most 10 MHz
// [R3] position valid 10 us after strobe falls
// [R4] first low bit, then 3-bit identifier, accepted
// [R5] bad identifier drops candidate, hunting resumes
// [R6] set ends when no further start follows
// [R7] idle line is held high
// [R8] response starts 10 us after request frame
// [R9] position sampled within 10 us of end
// [R10] echo, status, payload frames, then CRC frame
// [R11] command 4, 6, 8 payload layouts
// [R12] command A alarm; B, C alarm plus position
// [R13] four position bytes, least significant first
// [R14] 25-bit option zeroes top seven bits
// [R15] memory read: command, echo, address, value, CRC
// [R16] memory write: command, echo, address, value, CRC
// [R17] one shared half-duplex line, one driver
// [R18] strap high selects framed protocol; code picks it only when link setting is not RATE_SSI
// [R19] strap low selects clocked serial read
// [R20] link setting picks protocol and bit rate
// [R21] CRC covers set, mismatch discards set
// [R22] one bit per shift clock, idle on release
module epsl_top
  import epsl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic protocol_select_strap_i,
  input wire logic [1:0] link_rate_i,
  input wire logic request_strobe_n_i,
  input wire logic ssi_clk_i,
  input wire logic line_i,
  input wire logic [POS_W-1:0] position_i,
  input wire logic [7:0] alarm_flags_i,
  input wire logic [7:0] resolution_id_i,
  input wire logic pos25_mode_i,
  output logic position_serial_out_o,
  output logic line_o,
  output logic line_oe_o
);
  // =========================================================
  // pin synchronisers and mode
  logic [5:0] sy1_r, sy2_r;
  logic framed_r, fast_r, req_prev_r, sclk_prev_r;
  wire [5:0] pins = {protocol_select_strap_i, link_rate_i, request_strobe_n_i, ssi_clk_i, line_i};
  wire strap_s = sy2_r[5];
  wire [1:0] rate_s = sy2_r[4:3];
  wire req_s = sy2_r[2];
  wire sclk_s = sy2_r[1];
  wire line_s = sy2_r[0];
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      sy1_r <= SYNC_RST;
      sy2_r <= SYNC_RST;
      framed_r <= 1'b0;
      fast_r <= 1'b0;
      req_prev_r <= 1'b1;
      sclk_prev_r <= 1'b1;
    end
    else
    begin
      sy1_r <= pins;
      sy2_r <= sy1_r;
      framed_r <= strap_s && (rate_s != RATE_SSI); // see [R18] see [R19] see [R20]
      fast_r <= rate_s == RATE_FAST; // see [R20]
      req_prev_r <= req_s;
      sclk_prev_r <= sclk_s;
    end
  end
  wire req_fall = !framed_r && req_prev_r && !req_s; // see [R1]
  wire sclk_rise = sclk_s && !sclk_prev_r; // see [R2]
  wire [POS_W-1:0] pos_m = pos25_mode_i ? {{(POS_W-POS_KEEP_W){1'b0}},
    position_i[POS_KEEP_W-1:0]} : position_i; // see [R14]

  // =========================================================
  // clocked serial read
  epsl_ssi_t ssi_st_r;
  logic [TMR_W-1:0] ssi_tmr_r;
  logic [POS_W-1:0] ssi_sh_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || framed_r || req_s)
    begin
      ssi_st_r <= S_IDLE; // see [R22]
      ssi_tmr_r <= '0;
      position_serial_out_o <= 1'b1;
    end
    else
      case (ssi_st_r)
        S_IDLE:
          if (req_fall)
          begin
            ssi_st_r <= S_PROC; // see [R1]
            ssi_tmr_r <= '0;
            position_serial_out_o <= 1'b0;
          end
        S_PROC:
          if (ssi_tmr_r == REQ_CYC - 1'b1)
          begin
            ssi_st_r <= S_SHIFT; // see [R3]
            ssi_sh_r <= pos_m;
            position_serial_out_o <= pos_m[POS_W-1];
          end
          else
            ssi_tmr_r <= ssi_tmr_r + 1'b1;
        S_SHIFT:
          if (sclk_rise)
          begin
            ssi_sh_r <= ssi_sh_r << 1; // see [R22]
            position_serial_out_o <= ssi_sh_r[POS_W-2];
          end
        default:
          ssi_st_r <= S_IDLE;
      endcase
  end

  // =========================================================
  // framed receiver
  epsl_mst_t mst_r;
  logic rx_busy_r;
  logic [4:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [7:0] rx_sh_r;
  logic [2:0] nfr_r;
  wire [4:0] bit_cyc = fast_r ? BIT_CYC_FAST : BIT_CYC_SLOW;
  wire rx_en = framed_r && (mst_r == M_LISTEN); // see [R17]
  wire rx_tick = rx_busy_r && (rx_cnt_r == '0);
  wire rx_start = rx_en && !rx_busy_r && !line_s; // see [R4]
  wire sync_bad = rx_tick && (rx_idx_r == SYNC_IDX) && (nfr_r == '0)
    && ({line_s, rx_sh_r[7:6]} != CMD_SYNC); // see [R5]
  wire start_bad = rx_tick && (rx_idx_r == '0) && line_s;
  wire stop_bad = rx_tick && (rx_idx_r == FRAME_LAST) && !line_s;
  wire rx_done = rx_tick && (rx_idx_r == FRAME_LAST) && line_s;
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || !rx_en || sync_bad || start_bad || stop_bad || rx_done)
      rx_busy_r <= 1'b0; // see [R5]
    else if (rx_start)
    begin
      rx_busy_r <= 1'b1;
      rx_cnt_r <= bit_cyc >> 1;
      rx_idx_r <= '0;
    end
    else if (rx_tick)
    begin
      rx_cnt_r <= bit_cyc - 1'b1;
      rx_idx_r <= rx_idx_r + 1'b1;
      if (rx_idx_r != '0)
        rx_sh_r <= {line_s, rx_sh_r[7:1]};
    end
    else if (rx_busy_r)
      rx_cnt_r <= rx_cnt_r - 1'b1;
  end

  // =========================================================
  // frame set collection and sequencing
  epsl_req_t req_r;
  logic [POS_W-1:0] snap_r;
  logic [7:0] crc_rx_r, crc_tx_r, seq_byte;
  logic [7:0] mem_r [2**MEM_AW];
  logic [TMR_W-1:0] gap_r;
  logic [3:0] bidx_r;
  logic set_bad_r, disc_r;
  logic tx_busy_r;
  logic f_in_rdy, f_out_v;
  logic [7:0] f_out_d;
  wire [3:0] cmd = req_r.cf[6:3];
  wire is_alm_pos = (cmd == CMD_ALM_POS) || (cmd == CMD_ALM_POS_B) || (cmd == CMD_ALM_POS_C);
  wire is_pos = cmd == CMD_POS;
  wire is_res = cmd == CMD_RES;
  wire is_alm = cmd == CMD_ALM;
  wire is_rd = cmd == CMD_MEM_RD;
  wire is_wr = cmd == CMD_MEM_WR;
  wire is_mem = is_rd || is_wr;
  wire [2:0] exp_n = (is_alm_pos || is_pos || is_res || is_alm) ? NFR_POS
    : is_rd ? NFR_RD : is_wr ? NFR_WR : 3'h0;
  wire [3:0] tot_n = is_alm_pos ? TOT_ALM_POS : is_pos ? TOT_POS : TOT_SHORT;
  wire [TMR_W-1:0] gap_cyc = TMR_W'(bit_cyc) * GAP_BITS;
  wire set_end = (mst_r == M_LISTEN) && (nfr_r != '0) && !rx_busy_r
    && (gap_r >= gap_cyc); // see [R6]
  wire set_ok = !set_bad_r && (nfr_r == exp_n)
    && ((nfr_r == NFR_POS) || (crc_rx_r == '0)); // see [R21]
  wire push = (mst_r == M_BUILD) && f_in_rdy;
  wire last_push = push && (bidx_r == tot_n - 1'b1);
  wire [7:0] f_in_d = (bidx_r == tot_n - 1'b1) ? crc_tx_r : seq_byte; // see [R10]
  wire send_end = (mst_r == M_SEND) && !f_out_v && !tx_busy_r;
  wire [3:0] p = bidx_r - 4'h2;
  wire [1:0] pk = is_pos ? p[1:0] : p[1:0] - 2'h1;
  wire [7:0] pos_byte = snap_r[{pk, 3'b000} +: 8]; // see [R13]
  wire [7:0] mem_rd = mem_r[req_r.addr[MEM_AW-1:0]];
  always_comb
  begin
    if (bidx_r == '0)
      seq_byte = req_r.cf; // see [R10]
    else if (is_mem)
      seq_byte = (bidx_r == 4'h1) ? req_r.addr : mem_rd; // see [R15] see [R16]
    else if (bidx_r == 4'h1)
      seq_byte = {6'h00, fast_r, disc_r};
    else if (is_alm_pos || is_alm)
      seq_byte = (p == '0) ? alarm_flags_i : pos_byte; // see [R11] see [R12]
    else if (is_res)
      seq_byte = resolution_id_i; // see [R11]
    else
      seq_byte = pos_byte;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      disc_r <= 1'b0;
    else
      disc_r <= (disc_r && !(push && (bidx_r == 4'h1) && !is_mem)) || (set_end && !set_ok);
    if (srst_i || rx_done)
      gap_r <= srst_i ? RESP_CYC : '0;
    else if (gap_r != RESP_CYC)
      gap_r <= gap_r + 1'b1;
    if (rx_done && (nfr_r == '0))
      snap_r <= pos_m; // see [R9]
    if (set_end && set_ok && is_wr)
      mem_r[req_r.addr[MEM_AW-1:0]] <= req_r.wdata; // see [R16]
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || !framed_r || send_end || (set_end && !set_ok))
    begin
      mst_r <= M_LISTEN;
      nfr_r <= '0;
      set_bad_r <= 1'b0;
      crc_rx_r <= CRC_INIT;
    end
    else
      case (mst_r)
        M_LISTEN:
        begin
          set_bad_r <= set_bad_r || (stop_bad && (nfr_r != '0));
          if (rx_done)
          begin
            nfr_r <= (nfr_r == NFR_MAX) ? nfr_r : nfr_r + 1'b1;
            crc_rx_r <= epsl_crc8(crc_rx_r, rx_sh_r); // see [R21]
            case (nfr_r)
              3'h0: req_r.cf <= rx_sh_r;
              3'h1: req_r.addr <= rx_sh_r;
              3'h2: req_r.wdata <= rx_sh_r;
              default: ;
            endcase
          end
          if (set_end)
            mst_r <= M_WAIT;
        end
        M_WAIT:
          if (gap_r == RESP_CYC)
          begin
            mst_r <= M_BUILD; // see [R8]
            bidx_r <= '0;
            crc_tx_r <= CRC_INIT;
          end
        M_BUILD:
          if (push)
          begin
            bidx_r <= bidx_r + 1'b1;
            crc_tx_r <= epsl_crc8(crc_tx_r, seq_byte); // see [R21]
            if (last_push)
              mst_r <= M_SEND;
          end
        M_SEND: ;
        default:
          mst_r <= M_LISTEN;
      endcase
  end

  // =========================================================
  // response buffer and transmitter
  logic [4:0] tx_cnt_r;
  logic [3:0] tx_idx_r;
  logic [9:0] tx_sh_r;
  wire tx_on = (mst_r == M_BUILD) || (mst_r == M_SEND);
  wire tx_pop = tx_on && !tx_busy_r && f_out_v;
  wire tx_tick = tx_busy_r && (tx_cnt_r == '0);
  epsl_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .srst_i(srst_i || !framed_r),
    .in_valid_i(mst_r == M_BUILD),
    .in_data_i(f_in_d),
    .in_ready_o(f_in_rdy),
    .out_valid_o(f_out_v),
    .out_data_o(f_out_d),
    .out_ready_i(tx_on && !tx_busy_r)
  );
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || !framed_r || send_end)
    begin
      tx_busy_r <= 1'b0;
      line_o <= 1'b1; // see [R7]
      line_oe_o <= 1'b0; // see [R17]
    end
    else if (tx_pop)
    begin
      tx_sh_r <= {1'b1, f_out_d, 1'b0};
      tx_busy_r <= 1'b1;
      tx_cnt_r <= bit_cyc - 1'b1;
      tx_idx_r <= '0;
      line_o <= 1'b0;
      line_oe_o <= 1'b1;
    end
    else if (tx_tick)
    begin
      tx_cnt_r <= bit_cyc - 1'b1;
      tx_idx_r <= tx_idx_r + 1'b1;
      tx_sh_r <= {1'b0, tx_sh_r[9:1]};
      line_o <= (tx_idx_r == FRAME_LAST) ? 1'b1 : tx_sh_r[1]; // see [R7]
      if (tx_idx_r == FRAME_LAST)
        tx_busy_r <= 1'b0;
    end
    else if (tx_busy_r)
      tx_cnt_r <= tx_cnt_r - 1'b1;
  end

  // =========================================================
  // checks
  localparam int A_REQ = int'(REQ_CYC);
  localparam int A_RESP = int'(RESP_CYC);
  logic [TMR_W-1:0] h_ssi_r;
  logic [10:0] h_end_r;
  always_ff @(posedge ref_clk_i)
  begin
    h_ssi_r <= (srst_i || req_fall) ? '0 : h_ssi_r + TMR_W'(h_ssi_r != '1);
    h_end_r <= (srst_i || rx_done) ? '0 : h_end_r + 11'(h_end_r != '1);
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_ssi_ready;
    (ssi_st_r == S_SHIFT) && ($past(ssi_st_r) == S_PROC);
  endsequence
  sequence s_resp_start;
    $rose(line_oe_o);
  endsequence
  property p_ssi_idle;
    !framed_r && req_s |=> position_serial_out_o;
  endproperty
  a_ssi_idle: assert property (p_ssi_idle) else $error("serial out not idle high"); // see [R22]
  property p_ssi_wait;
    s_ssi_ready |-> (h_ssi_r == A_REQ) && !req_s;
  endproperty
  a_ssi_wait: assert property (p_ssi_wait) else $error("processing time wrong"); // see [R3]
  property p_ssi_bit;
    (ssi_st_r == S_SHIFT) |-> position_serial_out_o == ssi_sh_r[POS_W-1];
  endproperty
  a_ssi_bit: assert property (p_ssi_bit) else $error("serial bit mismatch"); // see [R22]
  property p_hunt;
    sync_bad |=> !rx_busy_r && (nfr_r == $past(nfr_r));
  endproperty
  a_hunt: assert property (p_hunt) else $error("bad candidate kept"); // see [R5]
  property p_accept;
    rx_done && (nfr_r == '0) && (mst_r == M_LISTEN) |-> rx_sh_r[2:0] == CMD_SYNC;
  endproperty
  a_accept: assert property (p_accept) else $error("frame without identifier"); // see [R4]
  property p_idle_high;
    line_oe_o && !tx_busy_r |-> line_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high"); // see [R7]
  property p_resp_delay;
    s_resp_start |-> (h_end_r >= A_RESP) && (h_end_r <= A_RESP + 8);
  endproperty
  a_resp_delay: assert property (p_resp_delay) else $error("response delay wrong"); // see [R8]
  property p_cf_first;
    s_resp_start |-> tx_sh_r[8:1] == req_r.cf && !line_o ##1 !line_o;
  endproperty
  a_cf_first: assert property (p_cf_first) else $error("first frame not echo"); // see [R10]
  property p_mask25;
    rx_done && (nfr_r == '0) && pos25_mode_i |=> snap_r[POS_W-1:POS_KEEP_W] == '0;
  endproperty
  a_mask25: assert property (p_mask25) else $error("top bits not cleared"); // see [R14]
  property p_half_duplex;
    line_oe_o |-> (mst_r != M_LISTEN) && !rx_busy_r;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("driving while listening"); // see [R17]
  property p_set_end;
    $rose(mst_r == M_WAIT) |-> ($past(gap_r) >= $past(gap_cyc)) && !$past(rx_busy_r);
  endproperty
  a_set_end: assert property (p_set_end) else $error("set ended early"); // see [R6]
endmodule

//--- rtl/epsl_pkg.sv
package epsl_pkg;
  // =========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam real REQ_TIME_US = 10.0;
  localparam real RESP_TIME_US = 10.0;
  localparam real RATE_SLOW_MHZ = 2.5;
  localparam real RATE_FAST_MHZ = 10.0;
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] REQ_CYC = TMR_W'(int'($ceil(REQ_TIME_US * CLK_MHZ)));
  localparam logic [TMR_W-1:0] RESP_CYC = TMR_W'(int'($ceil(RESP_TIME_US * CLK_MHZ)));
  localparam logic [4:0] BIT_CYC_SLOW = 5'(int'($floor(CLK_MHZ / RATE_SLOW_MHZ)));
  localparam logic [4:0] BIT_CYC_FAST = 5'(int'($floor(CLK_MHZ / RATE_FAST_MHZ)));
  localparam logic [TMR_W-1:0] GAP_BITS = 10'h002;
  // =========================================================
  // link setting, pins, frames
  localparam logic [1:0] RATE_SSI = 2'h0;
  localparam logic [1:0] RATE_FAST = 2'h3;
  localparam logic [5:0] SYNC_RST = 6'h07;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] SYNC_IDX = 4'h3;
  localparam logic [2:0] CMD_SYNC = 3'h2;
  // =========================================================
  // commands and frame set lengths
  localparam logic [3:0] CMD_ALM_POS = 4'h4;
  localparam logic [3:0] CMD_POS = 4'h6;
  localparam logic [3:0] CMD_RES = 4'h8;
  localparam logic [3:0] CMD_ALM = 4'hA;
  localparam logic [3:0] CMD_ALM_POS_B = 4'hB;
  localparam logic [3:0] CMD_ALM_POS_C = 4'hC;
  localparam logic [3:0] CMD_MEM_RD = 4'hD;
  localparam logic [3:0] CMD_MEM_WR = 4'hE;
  localparam logic [2:0] NFR_POS = 3'h1;
  localparam logic [2:0] NFR_RD = 3'h3;
  localparam logic [2:0] NFR_WR = 3'h4;
  localparam logic [2:0] NFR_MAX = 3'h7;
  localparam logic [3:0] TOT_ALM_POS = 4'h8;
  localparam logic [3:0] TOT_POS = 4'h7;
  localparam logic [3:0] TOT_SHORT = 4'h4;
  // =========================================================
  // data
  localparam int POS_W = 32;
  localparam int POS_KEEP_W = 25;
  localparam int BYTE_W = 8;
  localparam int MEM_AW = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef enum logic [1:0] {M_LISTEN, M_WAIT, M_BUILD, M_SEND} epsl_mst_t;
  typedef enum logic [1:0] {S_IDLE, S_PROC, S_SHIFT} epsl_ssi_t;
  typedef struct packed {
    logic [7:0] cf;
    logic [7:0] addr;
    logic [7:0] wdata;
  } epsl_req_t;

  function automatic logic [7:0] epsl_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    return r;
  endfunction
endpackage

//--- sim/epsl_master.sv
`timescale 1ns/1ps
// =========================================================
// master model: clocked serial read and half-duplex framed link
module epsl_master (
  input wire logic ref_clk_i,
  input wire logic line_i,
  input wire logic pos_out_i,
  output logic line_o,
  output logic request_strobe_n_o,
  output logic ssi_clk_o
);
  // idle line reads high because the master drives its line output high
  initial
  begin
    line_o = 1'b1;
    request_strobe_n_o = 1'b1;
    ssi_clk_o = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // start 0, data lsb first, stop 1, line left high afterwards
  task automatic send_byte(input logic [7:0] b, input int bc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_o = f[i];
      wait_cyc(bc);
    end
  endtask

  // samples each bit near its middle, sync on the start edge
  task automatic recv_byte(input int bc, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 4 * bc)
    begin
      wait_cyc(1);
      n++;
    end
    wait_cyc(bc / 2);
    ok = (line_i === 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      wait_cyc(bc);
      b[i] = line_i;
    end
    wait_cyc(bc);
    ok = ok && (line_i === 1'b1);
  endtask

  // shift clock of 160 ns stands high outside a read
  task automatic ssi_read(output logic [31:0] v, output logic early);
    request_strobe_n_o = 1'b0;
    wait_cyc(480);
    early = pos_out_i;
    wait_cyc(40);
    v[31] = pos_out_i;
    for (int i = 30; i >= 0; i--)
    begin
      ssi_clk_o = 1'b0;
      wait_cyc(3);
      ssi_clk_o = 1'b1;
      wait_cyc(5);
      v[i] = pos_out_i;
    end
    request_strobe_n_o = 1'b1;
  endtask
endmodule

//--- sim/test_encoder_position_serial_link.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("BAD %0t got %0h expected %0h", $time, (g), (e)); \
    end \
  end

module test_encoder_position_serial_link;
  import epsl_pkg::*;
  // =========================================================
  // signals
  logic ref_clk_i;
  logic srst_i = 1'b1;
  logic strap = 1'b0;
  logic [1:0] rate = 2'h0;
  logic [31:0] pos = 32'h0;
  logic [7:0] alarm = 8'h0;
  logic [7:0] res_id = 8'h0;
  logic pos25 = 1'b0;
  wire strobe_n, sclk, mst_line, dout, dev_line, dev_oe;
  wire line_w = dev_oe ? dev_line : mst_line;
  logic [31:0] rnd = 32'h3390481E;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic err_flag = 1'b0;
  logic [7:0] mem [16];
  logic [7:0] tx_q [$];
  logic [7:0] exp_q [$];
  logic [3:0] cmds [6] = '{CMD_ALM_POS, CMD_POS, CMD_RES, CMD_ALM, CMD_ALM_POS_B, CMD_ALM_POS_C};

  epsl_top dut (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .protocol_select_strap_i(strap),
    .link_rate_i(rate),
    .request_strobe_n_i(strobe_n),
    .ssi_clk_i(sclk),
    .line_i(line_w),
    .position_i(pos),
    .alarm_flags_i(alarm),
    .resolution_id_i(res_id),
    .pos25_mode_i(pos25),
    .position_serial_out_o(dout),
    .line_o(dev_line),
    .line_oe_o(dev_oe)
  );

  epsl_master mst (
    .ref_clk_i(ref_clk_i),
    .line_i(line_w),
    .pos_out_i(dout),
    .line_o(mst_line),
    .request_strobe_n_o(strobe_n),
    .ssi_clk_o(sclk)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // =========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  // bit-serial form, kept apart from the byte-wise one in the design
  function automatic logic [7:0] crc_of(input logic [7:0] q [$]);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    foreach (q[k])
      for (int i = 7; i >= 0; i--)
      begin
        fb = c[7] ^ q[k][i];
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    return c;
  endfunction

  task automatic step_rnd();
    rnd = lfsr_next(rnd);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks %0d", name, checks_done);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      $display("BAD %0t run too long", $time);
      print_verdict();
    end
  end

  // =========================================================
  // transactions
  task automatic framed_txn(input logic want);
    int bc;
    int n;
    logic [7:0] b;
    logic ok;
    bc = (rate == RATE_FAST) ? int'(BIT_CYC_FAST) : int'(BIT_CYC_SLOW);
    foreach (tx_q[i])
      mst.send_byte(tx_q[i], bc);
    step_rnd();
    n = 0;
    while (dev_oe !== 1'b1 && n < 700)
    begin
      @(negedge ref_clk_i);
      n++;
      // position moves after the snapshot, before the answer
      if (n == 3 * bc)
        pos = rnd;
    end
    if (!want)
    begin
      `CHK(dev_oe, 1'b0);
    end
    else
    begin
      `CHK(n >= 480 && n <= 530, 1'b1);
      foreach (exp_q[i])
      begin
        mst.recv_byte(bc, b, ok);
        `CHK({ok, b}, {1'b1, exp_q[i]});
      end
      repeat (bc + 4) @(negedge ref_clk_i);
      `CHK({dev_oe, line_w}, 2'b01);
    end
  endtask

  task automatic pos_cmd(input logic [3:0] cmd);
    logic [31:0] pm;
    logic [7:0] cb;
    logic [7:0] st;
    pm = pos25 ? {7'h00, pos[24:0]} : pos;
    cb = {1'b0, cmd, CMD_SYNC};
    st = {6'h00, rate == RATE_FAST, err_flag};
    err_flag = 1'b0;
    tx_q = {cb};
    exp_q = {cb, st};
    if (cmd inside {CMD_ALM_POS, CMD_ALM_POS_B, CMD_ALM_POS_C, CMD_ALM})
      exp_q.push_back(alarm);
    if (cmd == CMD_RES)
      exp_q.push_back(res_id);
    if (cmd inside {CMD_ALM_POS, CMD_POS, CMD_ALM_POS_B, CMD_ALM_POS_C})
      exp_q = {exp_q, pm[7:0], pm[15:8], pm[23:16], pm[31:24]};
    exp_q.push_back(crc_of(exp_q));
    framed_txn(1'b1);
  endtask

  task automatic mem_cmd(input logic wr, input logic [3:0] a, input logic bad_crc);
    logic [7:0] cb;
    logic [7:0] ab;
    logic [7:0] v;
    step_rnd();
    v = wr ? rnd[7:0] : mem[a];
    cb = {1'b0, wr ? CMD_MEM_WR : CMD_MEM_RD, CMD_SYNC};
    ab = {4'h0, a};
    tx_q = {cb, ab};
    if (wr)
      tx_q.push_back(v);
    tx_q.push_back(crc_of(tx_q) ^ {7'h00, bad_crc});
    exp_q = {cb, ab, v};
    exp_q.push_back(crc_of(exp_q));
    if (bad_crc)
      err_flag = 1'b1;
    else if (wr)
      mem[a] = v;
    framed_txn(!bad_crc);
  endtask

  task automatic ssi_case(input logic s, input logic [1:0] r, input logic p25);
    logic [31:0] v;
    logic early;
    strap = s;
    rate = r;
    pos25 = p25;
    step_rnd();
    // top bit set so early data would show when p25 is low
    pos = rnd | 32'h80000000;
    repeat (10) @(negedge ref_clk_i);
    mst.ssi_read(v, early);
    `CHK(early, 1'b0);
    `CHK(v, p25 ? {7'h00, pos[24:0]} : pos);
    repeat (6) @(negedge ref_clk_i);
    `CHK(dout, 1'b1);
    end_test("serial read");
  endtask

  // =========================================================
  // main sequence
  initial
  begin
    logic [3:0] a;
    repeat (3) @(negedge ref_clk_i);
    srst_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    `CHK({dev_oe, dout}, 2'b01);
    ssi_case(1'b0, RATE_FAST, 1'b0);
    ssi_case(1'b1, RATE_SSI, 1'b1);
    strap = 1'b1;
    rate = RATE_FAST;
    step_rnd();
    alarm = rnd[7:0];
    res_id = rnd[15:8];
    repeat (10) @(negedge ref_clk_i);
    foreach (cmds[i])
    begin
      pos25 = i[0];
      pos_cmd(cmds[i]);
    end
    end_test("position commands");
    step_rnd();
    a = rnd[3:0];
    mem_cmd(1'b1, a, 1'b0);
    mem_cmd(1'b1, a ^ 4'h9, 1'b0);
    mem_cmd(1'b0, a, 1'b0);
    mem_cmd(1'b0, a ^ 4'h9, 1'b0);
    end_test("memory");
    mem_cmd(1'b1, a, 1'b1);
    // start bit followed by an identifier of all ones
    tx_q = {8'hFF};
    framed_txn(1'b0);
    pos_cmd(CMD_POS);
    // accepted identifier, unknown command code
    tx_q = {8'h0A};
    err_flag = 1'b1;
    framed_txn(1'b0);
    pos_cmd(CMD_POS);
    end_test("refused sets");
    rate = 2'h1 + {1'b0, rnd[0]};
    repeat (10) @(negedge ref_clk_i);
    pos_cmd(CMD_ALM_POS);
    end_test("slow rate");
    print_verdict();
  end
endmodule
